/* File: fsrb_pkg.sv */
// Package for the fault status register bank: offsets, fields, reset values
package fsrb_pkg;

  // ---------------------------------------------------------------
  // Register offsets and frame layout
  // ---------------------------------------------------------------
  localparam logic [5:0] FSRB_OFS_SUMMARY = 6'h00;
  localparam logic [5:0] FSRB_OFS_THERMAL = 6'h01;
  localparam logic [5:0] FSRB_OFS_SUPPLY  = 6'h02;
  localparam logic [5:0] FSRB_OFS_CLEAR   = 6'h04;
  localparam logic [5:0] FSRB_OFS_LAST    = 6'h0c;
  localparam int         FSRB_FRAME_BITS  = 16;
  localparam int         FSRB_CLEAR_BIT   = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FSRB_RST_SUMMARY = 8'h00;
  localparam logic [7:0] FSRB_RST_THERMAL = 8'h00;
  localparam logic [7:0] FSRB_RST_SUPPLY  = 8'h00;

  // ---------------------------------------------------------------
  // Summary field positions
  // ---------------------------------------------------------------
  localparam int FSRB_SUM_STALL   = 7;
  localparam int FSRB_SUM_STEPDN  = 6;
  localparam int FSRB_SUM_SERIAL  = 5;
  localparam int FSRB_SUM_OVERCUR = 4;
  localparam int FSRB_SUM_NOPOR   = 3;
  localparam int FSRB_SUM_OVERV   = 2;
  localparam int FSRB_SUM_THERMAL = 1;
  localparam int FSRB_SUM_ANY     = 0;

  // ---------------------------------------------------------------
  // Second detail register field positions
  // ---------------------------------------------------------------
  localparam int FSRB_SUP_RSVD    = 7;
  localparam int FSRB_SUP_OTP     = 6;
  localparam int FSRB_SUP_SDOC    = 5;
  localparam int FSRB_SUP_SDUV    = 4;
  localparam int FSRB_SUP_CPUV    = 3;
  localparam int FSRB_SUP_PARITY  = 2;
  localparam int FSRB_SUP_FRAME   = 1;
  localparam int FSRB_SUP_ADDR    = 0;

  // Serial frame receiver states
  typedef enum logic [1:0] {FSRB_IDLE, FSRB_SHIFT, FSRB_DONE} fsrb_state_t;

endpackage

/* File: fsrb_sync.sv */
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
`default_nettype none
module fsrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             reset_n,  // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

  logic [WIDTH-1:0] stage_reg;

  // ---------------------------------------------------------------
  // Two stages, first stage read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      stage_reg <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end

endmodule
`default_nettype wire

/* File: fsrb_top.sv */
// Fault status register bank with its serial secondary port
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Unlisted offsets reserved, no defined function
// - Summary at 0h, resets 00h
// - Thermal/switch detail at 1h, resets 00h
// - Supply detail at 2h, bit7 zero
// - Summary bit0: any fault seen
// - Summary bit7: rotor stall
// - Summary bit6: step-down regulator fault
// - Summary bit5: any serial port fault
// - Summary bit4: any switch overcurrent
// - Summary bit3 low on supply reset
// - Summary bit2: supply overvoltage
// - Summary bit1: thermal warning or shutdown
// - Detail1 bit7: thermal warning
// - Detail1 bit6: thermal shutdown
// - Detail1 bits5..0: per-switch overcurrent
// - Detail2 bit6: programmable memory error
// - Detail2 bit5: step-down overcurrent
// - Detail2 bit4: step-down undervoltage
// - Detail2 bit3: charge pump undervoltage
// - Detail2 bit2 parity reads zero
// - Detail2 bit1: framing error
// - Detail2 bit0: bad address
// - Short frame latches framing error
// - Address above 0xC latches error
// - Clear command clears, self-returns to zero
// - Power-up and sleep restore defaults
module fsrb_top
  import fsrb_pkg::*;
(
  input  wire logic       clk_sys,          // System clock, 40 MHz
  input  wire logic       reset_n,          // Async power-up reset
  input  wire logic       sleep_n,          // Sleep pin, low sleeps
  input  wire logic       chip_select_n,    // Serial select pin
  input  wire logic       serial_clk,       // Serial clock pin
  input  wire logic       serial_in,        // Serial data in pin
  output logic            serial_out,       // Serial data out
  output logic            serial_out_en,    // Data out drive enable
  input  wire logic       rotor_stall_flag, // Stall detector
  input  wire logic       step_down_overcurrent,   // Regulator OC
  input  wire logic       step_down_undervoltage,  // Regulator UV
  input  wire logic       supply_power_reset,      // Supply reset seen
  input  wire logic       supply_overvoltage,      // Supply OV
  input  wire logic       thermal_warning,         // Warning level
  input  wire logic       thermal_shutdown,        // Shutdown level
  input  wire logic [5:0] switch_overcurrent,      // C-hi..A-lo
  input  wire logic       charge_pump_undervoltage, // Pump UV
  input  wire logic       otp_error,        // Memory error
  output logic [7:0]      fault_summary,    // Register 0h
  output logic [7:0]      thermal_and_switch_overcurrent, // 1h
  output logic [7:0]      supply_and_serial_errors,       // 2h
  output logic            fault_clear_command             // Clear pulse
);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  localparam int NPIN = 4;
  localparam int NDET = 15;
  logic [NPIN-1:0] pin_sync;
  logic [NDET-1:0] det_sync;
  logic            sleep_s, cs_n_s, sclk_s, sdi_s;

  fsrb_sync #(.WIDTH(NPIN)) u_pin_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({~sleep_n, ~chip_select_n, serial_clk, serial_in}),
    .sync_out (pin_sync)
  );

  fsrb_sync #(.WIDTH(NDET)) u_det_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({rotor_stall_flag, step_down_overcurrent,
                step_down_undervoltage, supply_power_reset,
                supply_overvoltage, thermal_warning, thermal_shutdown,
                switch_overcurrent, charge_pump_undervoltage,
                otp_error}),
    .sync_out (det_sync)
  );

  // Select and sleep travel inverted so the stages reset to idle levels
  assign {sleep_s, cs_n_s, sclk_s, sdi_s} = pin_sync ^ 4'hc;

  // Detector fields after synchronisation
  logic       det_stall, det_sdoc, det_sduv, det_por, det_ov;
  logic       det_otw, det_ots, det_cpuv, det_otp;
  logic [5:0] det_sw;
  assign {det_stall, det_sdoc, det_sduv, det_por, det_ov, det_otw,
          det_ots, det_sw, det_cpuv, det_otp} = det_sync;

  // ---------------------------------------------------------------
  // Serial clock and select edges
  // ---------------------------------------------------------------
  logic sclk_d_reg, cs_n_d_reg;
  logic sclk_fall, sclk_rise, cs_fall, cs_rise;

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end

  // Edge strobes on synchronised levels
  assign sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s & ~cs_n_s;
  assign cs_fall   = cs_n_d_reg & ~cs_n_s;
  assign cs_rise   = ~cs_n_d_reg & cs_n_s;

  // ---------------------------------------------------------------
  // Frame receiver
  // ---------------------------------------------------------------
  fsrb_state_t state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic        frame_ok, frame_short;
  logic        cmd_read;
  logic [5:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic [7:0]  rd_data;

  // Frame complete only with exactly sixteen clocks
  assign frame_ok    = cs_rise && (bit_cnt_reg == 5'(FSRB_FRAME_BITS))
                       && (state_reg == FSRB_SHIFT);
  assign frame_short = cs_rise && (bit_cnt_reg != 5'(FSRB_FRAME_BITS))
                       && (state_reg != FSRB_IDLE);
  assign cmd_read    = rx_reg[15];
  assign cmd_addr    = rx_reg[14:9];
  assign cmd_data    = rx_reg[7:0];

  // Receiver state and bit counter
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      state_reg   <= FSRB_IDLE;
      bit_cnt_reg <= '0;
    end
    else if (!sleep_s)
    begin
      state_reg   <= FSRB_IDLE;
      bit_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        FSRB_IDLE:
          if (cs_fall)
          begin
            state_reg   <= FSRB_SHIFT;
            bit_cnt_reg <= '0;
          end
        FSRB_SHIFT:
          if (cs_rise)
            state_reg <= FSRB_IDLE;
          else if (sclk_fall)
          begin
            if (bit_cnt_reg == 5'(FSRB_FRAME_BITS))
              state_reg <= FSRB_DONE;
            else
              bit_cnt_reg <= bit_cnt_reg + 5'd1;
          end
        FSRB_DONE:
          if (cs_rise)
            state_reg <= FSRB_IDLE;
        default:
          state_reg <= FSRB_IDLE;
      endcase
    end

  // Input shift register, data captured on falling clock
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      rx_reg <= '0;
    else if (sclk_fall && state_reg == FSRB_SHIFT)
      rx_reg <= {rx_reg[14:0], sdi_s};

  // Read mux on address bits after eight clocks, unmapped reads zero
  always_comb
  begin
    case (rx_reg[6:1])
      FSRB_OFS_SUMMARY: rd_data = fault_summary;
      FSRB_OFS_THERMAL: rd_data = thermal_and_switch_overcurrent;
      FSRB_OFS_SUPPLY:  rd_data = supply_and_serial_errors;
      default:          rd_data = 8'h00;
    endcase
  end

  // Output shift: status byte, then addressed register
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      tx_reg <= '0;
    else if (cs_fall)
      tx_reg <= {fault_summary, 8'h00};
    else if (state_reg == FSRB_SHIFT && sclk_fall
             && bit_cnt_reg == 5'd7)
      tx_reg <= {tx_reg[15:8], 8'h00};
    else if (state_reg == FSRB_SHIFT && sclk_fall
             && bit_cnt_reg == 5'd6)
      tx_reg <= tx_reg;
    else if (sclk_rise && bit_cnt_reg == 5'd8)
      tx_reg <= {rd_data, 8'h00};
    else if (sclk_rise && bit_cnt_reg != 5'd0)
      tx_reg <= {tx_reg[14:0], 1'b0};

  // Data out drives only while selected
  assign serial_out    = tx_reg[15];
  assign serial_out_en = ~cs_n_s & sleep_s;

  // ---------------------------------------------------------------
  // Clear command and serial error latches
  // ---------------------------------------------------------------
  logic clear_all, frame_err_reg, addr_err_reg, sleep_d_reg;
  logic sleep_pulse;

  // Leaving sleep acts as a reset pulse for latched faults
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      sleep_d_reg <= 1'b1;
    else
      sleep_d_reg <= sleep_s;

  assign sleep_pulse = ~sleep_d_reg & sleep_s;
  assign clear_all   = fault_clear_command | sleep_pulse | ~sleep_s;

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      fault_clear_command <= 1'b0;
    else
      fault_clear_command <= frame_ok && !cmd_read
        && cmd_addr == FSRB_OFS_CLEAR && cmd_data[FSRB_CLEAR_BIT];

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      frame_err_reg <= 1'b0;
    else if (frame_short || (cs_rise && state_reg == FSRB_DONE))
      frame_err_reg <= 1'b1;
    else if (clear_all)
      frame_err_reg <= 1'b0;

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      addr_err_reg <= 1'b0;
    else if (frame_ok && cmd_addr > FSRB_OFS_LAST)
      addr_err_reg <= 1'b1;
    else if (clear_all)
      addr_err_reg <= 1'b0;

  // ---------------------------------------------------------------
  // Latched detector flags
  // ---------------------------------------------------------------
  localparam int NLAT = 15;
  logic [NLAT-1:0] lat_reg;
  logic [NLAT-1:0] lat_in;
  assign lat_in = {det_stall, det_sdoc, det_sduv, det_por, det_ov,
                   det_otw, det_ots, det_sw, det_cpuv, det_otp};

  genvar gi;
  generate
    for (gi = 0; gi < NLAT; gi++)
    begin : g_lat
      always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
          lat_reg[gi] <= 1'b0;
        else if (lat_in[gi] && sleep_s)
          lat_reg[gi] <= 1'b1;
        else if (clear_all)
          lat_reg[gi] <= 1'b0;
    end
  endgenerate

  logic l_stall, l_sdoc, l_sduv, l_por, l_ov, l_otw, l_ots, l_cpuv;
  logic l_otp;
  logic [5:0] l_sw;
  assign {l_stall, l_sdoc, l_sduv, l_por, l_ov, l_otw, l_ots, l_sw,
          l_cpuv, l_otp} = lat_reg;

  // ---------------------------------------------------------------
  // Register images
  // ---------------------------------------------------------------
  logic [7:0] sum_next, thm_next, sup_next;

  always_comb
  begin
    thm_next = {l_otw, l_ots, l_sw};
    sup_next = {1'b0, l_otp, l_sdoc, l_sduv, l_cpuv, 1'b0,
                frame_err_reg, addr_err_reg};
    sum_next = '0;
    sum_next[FSRB_SUM_STALL]   = l_stall;
    sum_next[FSRB_SUM_STEPDN]  = l_sdoc | l_sduv;
    sum_next[FSRB_SUM_SERIAL]  = frame_err_reg | addr_err_reg;
    sum_next[FSRB_SUM_OVERCUR] = |l_sw;
    sum_next[FSRB_SUM_NOPOR]   = ~l_por;
    sum_next[FSRB_SUM_OVERV]   = l_ov;
    sum_next[FSRB_SUM_THERMAL] = l_otw | l_ots;
    sum_next[FSRB_SUM_ANY]     = l_stall | l_sdoc | l_sduv | l_ov
                                 | l_otw | l_ots | (|l_sw) | l_cpuv
                                 | l_otp | frame_err_reg | addr_err_reg
                                 | l_por;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      fault_summary                  <= FSRB_RST_SUMMARY;
      thermal_and_switch_overcurrent <= FSRB_RST_THERMAL;
      supply_and_serial_errors       <= FSRB_RST_SUPPLY;
    end
    else if (!sleep_s)
    begin
      fault_summary                  <= FSRB_RST_SUMMARY;
      thermal_and_switch_overcurrent <= FSRB_RST_THERMAL;
      supply_and_serial_errors       <= FSRB_RST_SUPPLY;
    end
    else
    begin
      fault_summary                  <= sum_next;
      thermal_and_switch_overcurrent <= thm_next;
      supply_and_serial_errors       <= sup_next;
    end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // reserved and parity
  property p_sup_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    supply_and_serial_errors[FSRB_SUP_RSVD] == 1'b0
    && supply_and_serial_errors[FSRB_SUP_PARITY] == 1'b0;
  endproperty
  a_sup_zero: assert property (p_sup_zero)
    else $error("reserved or parity bit set");

  property p_frame;
    @(posedge clk_sys) disable iff (!reset_n)
    (frame_short && sleep_s) |-> ##2 supply_and_serial_errors[1];
  endproperty
  a_frame: assert property (p_frame)
    else $error("short frame not flagged");

  property p_addr;
    @(posedge clk_sys) disable iff (!reset_n)
    (frame_ok && cmd_addr > FSRB_OFS_LAST && sleep_s)
      |-> ##2 supply_and_serial_errors[0];
  endproperty
  a_addr: assert property (p_addr)
    else $error("bad address not flagged");

  property p_clr;
    @(posedge clk_sys) disable iff (!reset_n)
    fault_clear_command |=> !fault_clear_command;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear command held");

  property p_sleep;
    @(posedge clk_sys) disable iff (!reset_n)
    !sleep_s |=> fault_summary == FSRB_RST_SUMMARY
      && supply_and_serial_errors == FSRB_RST_SUPPLY;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not restore defaults");

  property p_therm;
    @(posedge clk_sys) disable iff (!reset_n)
    $past(sleep_s) |-> fault_summary[FSRB_SUM_THERMAL]
      == $past(l_otw | l_ots);
  endproperty
  a_therm: assert property (p_therm)
    else $error("thermal summary mismatch");

  property p_oc;
    @(posedge clk_sys) disable iff (!reset_n)
    (sleep_s && |thermal_and_switch_overcurrent[5:0])
      |-> fault_summary[FSRB_SUM_OVERCUR];
  endproperty
  a_oc: assert property (p_oc)
    else $error("overcurrent summary missing");

  property p_any;
    @(posedge clk_sys) disable iff (!reset_n)
    (sleep_s && fault_summary[FSRB_SUM_SERIAL])
      |-> fault_summary[FSRB_SUM_ANY];
  endproperty
  a_any: assert property (p_any)
    else $error("fault summary missing");

endmodule
`default_nettype wire

/* File: fsrb_spi_ctrl.sv */
// Behavioural serial controller facing the fault status bank
`timescale 1ns/100ps
`default_nettype none
module fsrb_spi_ctrl (
  input  wire logic clk_sys,       // System clock
  output logic      chip_select_n, // Frame select, active low
  output logic      serial_clk,    // Serial clock, idles low
  output logic      serial_in,     // Data towards the device
  input  wire logic serial_out,    // Data from the device
  input  wire logic serial_out_en  // Device drive enable
);
  logic [15:0] rx_word; // Word shifted back by the device

  // Idle levels before the first frame
  initial
  begin
    chip_select_n = 1'b1;
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
    rx_word       = 16'h0000;
  end

  // Wait a number of system clocks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One frame of nbits, MSB first, even parity, clock low at select edges
  task automatic frame(input logic wr_n, input logic [5:0] addr,
                       input logic [7:0] data, input int nbits);
    logic [15:0] word;
    word = {wr_n, addr, ^{wr_n, addr, data}, data};
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    wait_clk(5);
    for (int i = 0; i < nbits; i++)
    begin
      serial_clk <= 1'b1;
      serial_in  <= (i < 16) ? word[15 - i] : ~serial_in;
      wait_clk(5);
      serial_clk <= 1'b0;
      rx_word    <= {rx_word[14:0], serial_out_en & serial_out};
      wait_clk(5);
    end
    // Released line shows the inverse of its last level
    chip_select_n <= 1'b1;
    serial_in     <= ~serial_in;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

/* File: fsrb_top_tb.sv */
// Self-checking testbench for the fault status register bank
`timescale 1ns/100ps
`default_nettype none
module fsrb_top_tb
  import fsrb_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_sys;
  logic        reset_n;
  logic        sleep_n;
  logic [14:0] det;        // Detector levels, see port map
  wire logic   chip_select_n;
  wire logic   serial_clk;
  wire logic   serial_in;
  wire logic   serial_out;
  wire logic   serial_out_en;
  logic [7:0]  fault_summary;
  logic [7:0]  thermal_and_switch_overcurrent;
  logic [7:0]  supply_and_serial_errors;
  logic        fault_clear_command;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          clr_cycles = 0; // Cycles with the clear pulse high
  int          clr_sent   = 0; // Clear writes issued

  // ---------------------------------------------------------------
  // Clock, instances and monitors
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  fsrb_top i_dut (
    .clk_sys                        (clk_sys),
    .reset_n                        (reset_n),
    .sleep_n                        (sleep_n),
    .chip_select_n                  (chip_select_n),
    .serial_clk                     (serial_clk),
    .serial_in                      (serial_in),
    .serial_out                     (serial_out),
    .serial_out_en                  (serial_out_en),
    .rotor_stall_flag               (det[0]),
    .step_down_overcurrent          (det[1]),
    .step_down_undervoltage         (det[2]),
    .supply_power_reset             (det[3]),
    .supply_overvoltage             (det[4]),
    .thermal_warning                (det[5]),
    .thermal_shutdown               (det[6]),
    .charge_pump_undervoltage       (det[7]),
    .otp_error                      (det[8]),
    .switch_overcurrent             (det[14:9]),
    .fault_summary                  (fault_summary),
    .thermal_and_switch_overcurrent (thermal_and_switch_overcurrent),
    .supply_and_serial_errors       (supply_and_serial_errors),
    .fault_clear_command            (fault_clear_command)
  );

  fsrb_spi_ctrl i_ctrl (
    .clk_sys       (clk_sys),
    .chip_select_n (chip_select_n),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_en (serial_out_en)
  );

  // Count cycles of the self-returning clear pulse
  always @(posedge clk_sys)
    if (fault_clear_command === 1'b1)
      clr_cycles <= clr_cycles + 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic compare8(input logic [7:0] act, input logic [7:0] exp);
    cmp_count++;
    if (act !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  function automatic logic [7:0] exp_sum(input logic [14:0] d,
                                         input logic fe, input logic ae);
    logic [7:0] s;
    s[FSRB_SUM_STALL]   = d[0];
    s[FSRB_SUM_STEPDN]  = d[1] | d[2];
    s[FSRB_SUM_SERIAL]  = fe | ae;
    s[FSRB_SUM_OVERCUR] = |d[14:9];
    s[FSRB_SUM_NOPOR]   = ~d[3];
    s[FSRB_SUM_OVERV]   = d[4];
    s[FSRB_SUM_THERMAL] = d[5] | d[6];
    s[FSRB_SUM_ANY]     = (|d) | fe | ae;
    return s;
  endfunction

  // Compare all three images against latched causes
  task automatic expect_bank(input logic [14:0] d,
                             input logic fe, input logic ae);
    compare8(fault_summary, exp_sum(d, fe, ae));
    compare8(thermal_and_switch_overcurrent, {d[5], d[6], d[14:9]});
    compare8(supply_and_serial_errors,
             {1'b0, d[8], d[1], d[2], d[7], 1'b0, fe, ae});
  endtask

  // Compare all three images against reset values
  task automatic expect_reset;
    compare8(fault_summary, FSRB_RST_SUMMARY);
    compare8(thermal_and_switch_overcurrent, FSRB_RST_THERMAL);
    compare8(supply_and_serial_errors, FSRB_RST_SUPPLY);
  endtask

  // write one to the clear bit
  task automatic clear_faults;
    i_ctrl.frame(1'b0, FSRB_OFS_CLEAR, 8'h01, FSRB_FRAME_BITS);
    clr_sent++;
    wait_clk(4);
  endtask

  // Pulse one detector pattern, then let it latch
  task automatic pulse_det(input logic [14:0] d);
    det <= d;
    wait_clk(4);
    det <= 15'h0000;
    wait_clk(8);
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    sleep_n = 1'b1;
    det     = 15'h0000;
    wait_clk(2);
    expect_reset();
    compare8({7'h00, fault_clear_command}, 8'h00);
    wait_clk(2);
    reset_n <= 1'b1;
    wait_clk(6);
    expect_bank(15'h0000, 1'b0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 15; i++)
    begin
      pulse_det(15'h0001 << i);
      expect_bank(15'h0001 << i, 1'b0, 1'b0);
      clear_faults();
      expect_bank(15'h0000, 1'b0, 1'b0);
    end
    $display("test detectors done");
    pulse_det(15'h7e41);
    for (int a = 0; a < 3; a++)
      i_ctrl.frame(1'b0, 6'(a), 8'hff, FSRB_FRAME_BITS);
    expect_bank(15'h7e41, 1'b0, 1'b0);
    i_ctrl.frame(1'b1, FSRB_OFS_THERMAL, 8'h00, FSRB_FRAME_BITS);
    compare8(i_ctrl.rx_word[15:8], exp_sum(15'h7e41, 1'b0, 1'b0));
    compare8(i_ctrl.rx_word[7:0], 8'h7f);
    clear_faults();
    compare8(8'(clr_cycles), 8'(clr_sent));
    $display("test writes done");
    i_ctrl.frame(1'b1, FSRB_OFS_SUMMARY, 8'h00, 12);
    expect_bank(15'h0000, 1'b1, 1'b0);
    clear_faults();
    i_ctrl.frame(1'b1, FSRB_OFS_SUMMARY, 8'h00, 17);
    expect_bank(15'h0000, 1'b1, 1'b0);
    clear_faults();
    expect_bank(15'h0000, 1'b0, 1'b0);
    $display("test framing done");
    i_ctrl.frame(1'b1, FSRB_OFS_LAST, 8'h00, FSRB_FRAME_BITS);
    expect_bank(15'h0000, 1'b0, 1'b0);
    i_ctrl.frame(1'b1, 6'h0d, 8'h00, FSRB_FRAME_BITS);
    expect_bank(15'h0000, 1'b0, 1'b1);
    i_ctrl.frame(1'b1, FSRB_OFS_THERMAL, 8'h00, 8);
    expect_bank(15'h0000, 1'b1, 1'b1);
    clear_faults();
    expect_bank(15'h0000, 1'b0, 1'b0);
    $display("test address done");
    pulse_det(15'h0011);
    sleep_n <= 1'b0;
    wait_clk(6);
    expect_reset();
    sleep_n <= 1'b1;
    wait_clk(6);
    expect_bank(15'h0000, 1'b0, 1'b0);
    pulse_det(15'h0100);
    reset_n <= 1'b0;
    wait_clk(2);
    expect_reset();
    reset_n <= 1'b1;
    wait_clk(6);
    expect_bank(15'h0000, 1'b0, 1'b0);
    compare8(8'(clr_cycles), 8'(clr_sent));
    $display("test sleep done");
    results();
  end

  // Watchdog well beyond the expected run of some 5100 cycles
  initial
  begin
    wait_clk(30000);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
